// file: dv/pnl_ctrl_model.sv
// Behavioural display controller that feeds the panel pixel stream
`timescale 1ns/10ps

module pnl_ctrl_model #(
  parameter int ACT_PIX   = 8,
  parameter int ACT_LINES = 3
) (
  output logic       o_strobe,
  output logic       o_line_valid,
  output logic [5:0] o_red,
  output logic [5:0] o_green,
  output logic [5:0] o_blue
);
  logic [41:0] exp_q [$];
  int          row = 0;
  logic [17:0] colour_tab [8] = '{18'h00000, 18'h3FFFF, 18'h3F000, 18'h00FC0,
                                  18'h0003F, 18'h3FFC0, 18'h3F03F, 18'h00FFF};

  // Strobe at 12.5 MHz, kept running through blanks so the panel sees them
  initial begin
    {o_strobe, o_line_valid, o_red, o_green, o_blue} = '0;
    #13;
    forever #40 o_strobe = ~o_strobe;
  end

  // Low strobes with junk data that changes every cycle
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge o_strobe);
      o_line_valid <= 1'b0;
      {o_red, o_green, o_blue} <= 18'($urandom);
    end
  endtask

  // One line: colour bars on row 0, random pixels elsewhere
  task automatic send_line(input int width, input int gap);
    logic [17:0] pix;
    for (int i = 0; i < width; i++) begin
      pix = (row == 0 && i < 8) ? colour_tab[i] : 18'($urandom);
      @(posedge o_strobe);
      o_line_valid <= 1'b1;
      {o_red, o_green, o_blue} <= pix;
      if (i < ACT_PIX && row < ACT_LINES)
        exp_q.push_back({pix, 11'(i), 11'(row), pix == 18'h0, &pix});
    end
    idle(gap);
    row++;
  endtask

  // Vertical blank closes the frame and restarts the row count
  task automatic blank(input int n);
    idle(n);
    row = 0;
  endtask
endmodule  // pnl_ctrl_model

// file: dv/pnl_panel_in_bench.sv
// Self-checking bench for the panel pixel input stage
`timescale 1ns/10ps

`define PNL_CHECK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("FAIL t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
  end

module pnl_panel_in_bench
  import pnl_pkg::*;
;
  logic        i_mclk = 1'b0;
  logic        i_reset = 1'b1;
  logic        i_clk_en = 1'b1;
  wire         strobe;
  wire         line_valid;
  wire  [5:0]  red;
  wire  [5:0]  green;
  wire  [5:0]  blue;
  logic        o_pix_valid;
  pnl_pix_s    o_pix;
  logic [10:0] o_pix_col;
  logic [10:0] o_pix_row;
  logic        o_pix_black;
  logic        o_pix_white;
  logic        o_frame_done;
  pnl_err_s    o_err;
  logic [15:0] o_frame_count;
  logic [41:0] exp_pix;
  int          n_errors = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          cnt [6] = '{0, 0, 0, 0, 0, 0};

  pnl_panel_in #(.ACT_PIX(8), .ACT_LINES(3), .LINE_MIN(20), .LINE_MAX(24),
    .FRAME_TMO(2000)) i_pnl_panel_in (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_clk_en(i_clk_en),
    .i_pixel_sample_strobe(strobe), .i_line_valid(line_valid), .i_red_bits(red),
    .i_green_bits(green), .i_blue_bits(blue), .o_pix_valid(o_pix_valid), .o_pix(o_pix),
    .o_pix_col(o_pix_col), .o_pix_row(o_pix_row), .o_pix_black(o_pix_black),
    .o_pix_white(o_pix_white), .o_frame_done(o_frame_done), .o_err(o_err),
    .o_frame_count(o_frame_count));

  pnl_ctrl_model i_pnl_ctrl_model (
    .o_strobe(strobe), .o_line_valid(line_valid), .o_red(red), .o_green(green),
    .o_blue(blue));

  // System clock, 40 ns period
  always #20 i_mclk = ~i_mclk;

  // Tally event pulses and cut a hang short
  always @(posedge i_mclk) begin
    cycles++;
    cnt[0] += int'(o_frame_done === 1'b1);
    cnt[1] += int'(o_err.line_short === 1'b1);
    cnt[2] += int'(o_err.width_bad === 1'b1);
    cnt[3] += int'(o_err.pix_count_bad === 1'b1);
    cnt[4] += int'(o_err.line_count_bad === 1'b1);
    cnt[5] += int'(o_err.frame_slow === 1'b1);
    if (cycles == 10000) begin
      n_errors++;
      give_verdict();
    end
  end

  // Take the oldest noted pixel off the queue for every output pixel
  always @(posedge strobe) begin
    if (o_pix_valid === 1'b1) begin
      if (i_pnl_ctrl_model.exp_q.size() == 0)
        `PNL_CHECK(o_pix_valid, 1'b0)
      else begin
        exp_pix = i_pnl_ctrl_model.exp_q.pop_front();
        `PNL_CHECK({o_pix, o_pix_col, o_pix_row, o_pix_black, o_pix_white}, exp_pix)
      end
    end
  end

  // Compare event tallies with the expected totals
  task automatic check_events(input int fd, input int ls, input int wb, input int pc,
                              input int lc, input int fs);
    `PNL_CHECK(cnt[0], fd)
    `PNL_CHECK(o_frame_count, 16'(fd))
    `PNL_CHECK(cnt[1], ls)
    `PNL_CHECK(cnt[2], wb)
    `PNL_CHECK(cnt[3], pc)
    `PNL_CHECK(cnt[4], lc)
    `PNL_CHECK(cnt[5], fs)
    `PNL_CHECK({o_frame_done, o_err}, 6'h0)
  endtask

  // Print the counts and the verdict, then stop
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial begin
    void'($urandom(93));
    repeat (6) @(posedge i_mclk);
    i_reset <= 1'b0;
    repeat (4) @(posedge i_mclk);
    `PNL_CHECK({o_pix_valid, o_frame_done, o_err, o_frame_count}, 23'h0)
    i_pnl_ctrl_model.blank(30);
    repeat (3) i_pnl_ctrl_model.send_line(8, 13);
    i_pnl_ctrl_model.blank(30);
    repeat (20) @(posedge i_mclk);
    check_events(1, 0, 0, 0, 0, 0);
    // Frozen block must not time out
    i_clk_en <= 1'b0;
    repeat (2500) @(posedge i_mclk);
    check_events(1, 0, 0, 0, 0, 0);
    i_clk_en <= 1'b1;
    i_pnl_ctrl_model.idle(4);
    // Short period, narrow line-valid, wide line-valid, one line too many
    i_pnl_ctrl_model.send_line(8, 5);
    i_pnl_ctrl_model.send_line(1, 20);
    i_pnl_ctrl_model.send_line(16, 10);
    i_pnl_ctrl_model.send_line(8, 13);
    i_pnl_ctrl_model.blank(30);
    repeat (20) @(posedge i_mclk);
    check_events(2, 1, 2, 2, 1, 0);
    // No further frame: slow-frame fault after the timeout
    repeat (2300) @(posedge i_mclk);
    check_events(2, 1, 2, 2, 1, 1);
    `PNL_CHECK(i_pnl_ctrl_model.exp_q.size(), 0)
    give_verdict();
  end
endmodule  // pnl_panel_in_bench

// file: hdl/pnl_defines.svh
// Constants for the parallel RGB panel input block
`ifndef PNL_DEFINES_SVH
`define PNL_DEFINES_SVH

// Field and counter widths
`define PNL_CHAN_W        6
`define PNL_CNT_W         11
`define PNL_FCNT_W        16
`define PNL_TMO_W         20
`define PNL_EVT_N         5

// Event vector bit positions
`define PNL_EV_FRAME      0
`define PNL_EV_SHORT      1
`define PNL_EV_WIDTH      2
`define PNL_EV_PIXCNT     3
`define PNL_EV_LINECNT    4

// Active area in pixel strobe cycles and lines
`define PNL_ACT_PIX       800
`define PNL_ACT_LINES     600

// Line period limits in pixel strobe cycles
`define PNL_LINE_MIN      944
`define PNL_LINE_TYP      1056
`define PNL_LINE_MAX      1064

// Line-valid width limits in pixel strobe cycles
`define PNL_LV_MIN        2
`define PNL_LV_MARGIN     10

// Strobe rate limits in MHz and minimum period in ps
`define PNL_PIX_MAX_MHZ   42
`define PNL_PIX_MIN_PS    23800

// Longest frame period in ns and the system clock rate in MHz
`define PNL_FRAME_MAX_NS  17850000
`define PNL_MCLK_MHZ      25

`endif

// file: hdl/pnl_evt_sync.sv
// Toggle crossing of one-cycle event pulses between two clock domains
`timescale 1ns/10ps

module pnl_evt_sync #(
  parameter int N = 1
) (
  input  wire logic         i_src_clk,
  input  wire logic         i_src_rst,
  input  wire logic         i_src_en,
  input  wire logic [N-1:0] i_src_evt,
  input  wire logic         i_dst_clk,
  input  wire logic         i_dst_rst,
  input  wire logic         i_dst_en,
  output logic      [N-1:0] o_dst_evt
);

  logic [N-1:0] src_tog;
  logic [N-1:0] dst_meta;
  logic [N-1:0] dst_sync;
  logic [N-1:0] dst_prev;

  // Each source event flips its toggle
  always_ff @(posedge i_src_clk) begin
    if (i_src_rst) begin
      src_tog <= '0;
    end else if (i_src_en) begin
      src_tog <= src_tog ^ i_src_evt;
    end
  end

  // Two flip-flops, then a third for the change detect
  always_ff @(posedge i_dst_clk) begin
    if (i_dst_rst) begin
      dst_meta <= '0;
      dst_sync <= '0;
      dst_prev <= '0;
    end else if (i_dst_en) begin
      dst_meta <= src_tog;
      dst_sync <= dst_meta;
      dst_prev <= dst_sync;
    end
  end

  // A change of the synchronised toggle is one event
  assign o_dst_evt = (dst_sync ^ dst_prev) & {N{i_dst_en}};

endmodule // pnl_evt_sync

// file: hdl/pnl_panel_in.sv
// Pixel input stage of an 800 by 600 panel fed with parallel 18-bit RGB
`timescale 1ns/10ps

`include "pnl_defines.svh"

// Behaviour
// - Exactly 800 active pixels per line
// - Exactly 600 active lines per frame
// - Channels are 6-bit intensities, bit 0 lowest
// - All low black, all high white
// - All data and line-valid sampled on strobe
module pnl_panel_in
  import pnl_pkg::*;
#(
  parameter int ACT_PIX   = `PNL_ACT_PIX,
  parameter int ACT_LINES = `PNL_ACT_LINES,
  parameter int LINE_MIN  = `PNL_LINE_MIN,
  parameter int LINE_MAX  = `PNL_LINE_MAX,
  parameter int LV_MIN    = `PNL_LV_MIN,
  parameter int LV_MARGIN = `PNL_LV_MARGIN,
  parameter int FRAME_TMO = (`PNL_FRAME_MAX_NS / 1000) * `PNL_MCLK_MHZ
) (
  input  wire logic                   i_mclk,
  input  wire logic                   i_reset,
  input  wire logic                   i_clk_en,
  input  wire logic                   i_pixel_sample_strobe,
  input  wire logic                   i_line_valid,
  input  wire logic [`PNL_CHAN_W-1:0] i_red_bits,
  input  wire logic [`PNL_CHAN_W-1:0] i_green_bits,
  input  wire logic [`PNL_CHAN_W-1:0] i_blue_bits,
  output logic                        o_pix_valid,
  output pnl_pix_s                    o_pix,
  output logic      [`PNL_CNT_W-1:0]  o_pix_col,
  output logic      [`PNL_CNT_W-1:0]  o_pix_row,
  output logic                        o_pix_black,
  output logic                        o_pix_white,
  output logic                        o_frame_done,
  output pnl_err_s                    o_err,
  output logic      [`PNL_FCNT_W-1:0] o_frame_count
);

  localparam logic [`PNL_CNT_W-1:0] ACT_PIX_C   = `PNL_CNT_W'(ACT_PIX);
  localparam logic [`PNL_CNT_W-1:0] ACT_LINES_C = `PNL_CNT_W'(ACT_LINES);
  localparam logic [`PNL_CNT_W-1:0] LINE_MIN_C  = `PNL_CNT_W'(LINE_MIN);
  localparam logic [`PNL_CNT_W-1:0] IDLE_END_C  = `PNL_CNT_W'(LINE_MAX - 1);
  localparam logic [`PNL_CNT_W-1:0] LV_MIN_C    = `PNL_CNT_W'(LV_MIN);
  localparam logic [`PNL_CNT_W-1:0] LV_MAX_C    = `PNL_CNT_W'(LINE_MAX - LV_MARGIN);
  localparam logic [`PNL_TMO_W-1:0] TMO_LAST_C  = `PNL_TMO_W'(FRAME_TMO - 1);

  // Saturating increment shared by the link-domain counters
  function automatic logic [`PNL_CNT_W-1:0] sat_inc(input logic [`PNL_CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + `PNL_CNT_W'(1);
  endfunction

  // Channel at full intensity
  function automatic logic chan_full(input logic [`PNL_CHAN_W-1:0] c);
    chan_full = &c;
  endfunction

  // ---------------- Link domain, clocked by the pixel strobe ----------------

  logic                     rst_meta;
  logic                     link_rst;
  logic                     en_meta;
  logic                     link_en;
  logic                     cap_valid;
  logic                     prev_valid;
  pnl_pix_s                 cap_pix;
  logic [`PNL_CNT_W-1:0]    col_cnt;
  logic [`PNL_CNT_W-1:0]    row_cnt;
  logic [`PNL_CNT_W-1:0]    per_cnt;
  logic [`PNL_CNT_W-1:0]    idle_cnt;
  logic                     have_line;
  logic [`PNL_EVT_N-1:0]    link_evt;
  logic [`PNL_EVT_N-1:0]    sys_evt;

  // Reset and enable carried into the link domain by two flip-flops
  always_ff @(posedge i_pixel_sample_strobe) begin
    rst_meta <= i_reset;
    link_rst <= rst_meta;
    en_meta  <= i_clk_en;
    link_en  <= en_meta;
  end

  // Every data line and line-valid taken on the strobe edge
  always_ff @(posedge i_pixel_sample_strobe) begin
    if (link_rst) begin
      cap_valid  <= 1'b0;
      prev_valid <= 1'b0;
      cap_pix    <= '0;
    end else if (link_en) begin
      cap_valid  <= i_line_valid;
      prev_valid <= cap_valid;
      cap_pix    <= '{red: i_red_bits, green: i_green_bits, blue: i_blue_bits};
    end
  end

  // Line and frame decoding
  logic line_start;
  logic line_end;
  logic blank_hit;
  logic accept;
  assign line_start = cap_valid & ~prev_valid;
  assign line_end   = ~cap_valid & prev_valid;
  assign blank_hit  = ~cap_valid && (idle_cnt == IDLE_END_C);
  assign accept     = cap_valid && (col_cnt < ACT_PIX_C) && (row_cnt < ACT_LINES_C);

  // Fault and frame events, each one strobe cycle long
  assign link_evt[`PNL_EV_FRAME]   = blank_hit && (row_cnt != '0);
  assign link_evt[`PNL_EV_SHORT]   = line_start && have_line && (per_cnt < LINE_MIN_C);
  assign link_evt[`PNL_EV_WIDTH]   = line_end && ((col_cnt < LV_MIN_C) || (col_cnt > LV_MAX_C));
  assign link_evt[`PNL_EV_PIXCNT]  = line_end && (col_cnt != ACT_PIX_C);
  assign link_evt[`PNL_EV_LINECNT] = link_evt[`PNL_EV_FRAME] && (row_cnt != ACT_LINES_C);

  // Column restarts with every line-valid interval
  always_ff @(posedge i_pixel_sample_strobe) begin
    if (link_rst) begin
      col_cnt <= '0;
    end else if (link_en) begin
      col_cnt <= cap_valid ? sat_inc(col_cnt) : '0;
    end
  end

  // Line index advances at each line end and clears in vertical blank
  always_ff @(posedge i_pixel_sample_strobe) begin
    if (link_rst) begin
      row_cnt <= '0;
    end else if (link_en) begin
      if (blank_hit) begin
        row_cnt <= '0;
      end else if (line_end) begin
        row_cnt <= sat_inc(row_cnt);
      end
    end
  end

  // Line period and idle gap counters
  always_ff @(posedge i_pixel_sample_strobe) begin
    if (link_rst) begin
      per_cnt   <= '0;
      idle_cnt  <= '0;
      have_line <= 1'b0;
    end else if (link_en) begin
      per_cnt  <= line_start ? `PNL_CNT_W'(1) : sat_inc(per_cnt);
      idle_cnt <= cap_valid ? '0 : sat_inc(idle_cnt);
      if (blank_hit) begin
        have_line <= 1'b0;
      end else if (line_start) begin
        have_line <= 1'b1;
      end
    end
  end

  // Accepted pixels handed on with their screen position
  always_ff @(posedge i_pixel_sample_strobe) begin
    if (link_rst) begin
      o_pix_valid <= 1'b0;
      o_pix       <= '0;
      o_pix_col   <= '0;
      o_pix_row   <= '0;
      o_pix_black <= 1'b0;
      o_pix_white <= 1'b0;
    end else if (link_en) begin
      o_pix_valid <= accept;
      if (accept) begin
        o_pix       <= cap_pix;
        o_pix_col   <= col_cnt;
        o_pix_row   <= row_cnt;
        o_pix_black <= (cap_pix == '0);
        o_pix_white <= chan_full(cap_pix.red) && chan_full(cap_pix.green)
                       && chan_full(cap_pix.blue);
      end
    end
  end

  // Events cross to the system clock as toggles
  pnl_evt_sync #(
    .N (`PNL_EVT_N)
  ) u_evt_sync (
    .i_src_clk (i_pixel_sample_strobe),
    .i_src_rst (link_rst),
    .i_src_en  (link_en),
    .i_src_evt (link_evt),
    .i_dst_clk (i_mclk),
    .i_dst_rst (i_reset),
    .i_dst_en  (i_clk_en),
    .o_dst_evt (sys_evt)
  );

  // ---------------- System domain ----------------

  logic [`PNL_TMO_W-1:0] tmo_cnt;
  logic                  tmo_hit;
  assign tmo_hit = (tmo_cnt == TMO_LAST_C);

  // Frame watchdog flags a frame period longer than allowed
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      tmo_cnt <= '0;
    end else if (i_clk_en) begin
      if (sys_evt[`PNL_EV_FRAME] || tmo_hit) begin
        tmo_cnt <= '0;
      end else begin
        tmo_cnt <= tmo_cnt + `PNL_TMO_W'(1);
      end
    end
  end

  // Registered event pulses and frame count
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_frame_done  <= 1'b0;
      o_err         <= '0;
      o_frame_count <= '0;
    end else if (i_clk_en) begin
      o_frame_done         <= sys_evt[`PNL_EV_FRAME];
      o_err.line_short     <= sys_evt[`PNL_EV_SHORT];
      o_err.width_bad      <= sys_evt[`PNL_EV_WIDTH];
      o_err.pix_count_bad  <= sys_evt[`PNL_EV_PIXCNT];
      o_err.line_count_bad <= sys_evt[`PNL_EV_LINECNT];
      o_err.frame_slow     <= tmo_hit && !sys_evt[`PNL_EV_FRAME];
      if (sys_evt[`PNL_EV_FRAME]) begin
        o_frame_count <= o_frame_count + `PNL_FCNT_W'(1);
      end
    end
  end

  // ---------------- Checks in the link domain ----------------

  sequence s_line_open;
    !cap_valid ##1 cap_valid && (row_cnt < ACT_LINES_C);
  endsequence

  sequence s_two_pixels;
    o_pix_valid ##1 o_pix_valid;
  endsequence

  chk_first_column: assert property (
    @(posedge i_pixel_sample_strobe) disable iff (link_rst || !link_en)
    s_line_open |=> o_pix_valid && (o_pix_col == '0))
    else $error("first pixel of a line not at column zero");

  chk_column_step: assert property (
    @(posedge i_pixel_sample_strobe) disable iff (link_rst || !link_en)
    s_two_pixels |-> o_pix_col == $past(o_pix_col) + `PNL_CNT_W'(1))
    else $error("column did not advance by one");

  chk_column_limit: assert property (
    @(posedge i_pixel_sample_strobe) disable iff (link_rst || !link_en)
    o_pix_valid |-> o_pix_col < ACT_PIX_C)
    else $error("pixel accepted beyond the active width");

  chk_row_limit: assert property (
    @(posedge i_pixel_sample_strobe) disable iff (link_rst || !link_en)
    o_pix_valid |-> o_pix_row < ACT_LINES_C)
    else $error("pixel accepted beyond the active height");

  chk_valid_gate: assert property (
    @(posedge i_pixel_sample_strobe) disable iff (link_rst || !link_en)
    o_pix_valid |-> $past(i_line_valid, 2))
    else $error("pixel passed without line valid two strobes earlier");

  chk_bits_order: assert property (
    @(posedge i_pixel_sample_strobe) disable iff (link_rst || !link_en)
    ##2 o_pix_valid |-> o_pix.red == $past(i_red_bits, 2)
                        && o_pix.green == $past(i_green_bits, 2)
                        && o_pix.blue == $past(i_blue_bits, 2))
    else $error("channel bits not carried in order");

  chk_black_white: assert property (
    @(posedge i_pixel_sample_strobe) disable iff (link_rst || !link_en)
    o_pix_valid |-> (o_pix_black == (o_pix == '0))
                    && (o_pix_white == (&o_pix)))
    else $error("black or white flag disagrees with pixel");

endmodule // pnl_panel_in

// file: hdl/pnl_pkg.sv
// Types shared by the parallel RGB panel input block
`include "pnl_defines.svh"

package pnl_pkg;

  // One sampled pixel, bit 0 of each channel is its lowest data line
  typedef struct packed {
    logic [`PNL_CHAN_W-1:0] red;
    logic [`PNL_CHAN_W-1:0] green;
    logic [`PNL_CHAN_W-1:0] blue;
  } pnl_pix_s;

  // Timing fault pulses reported in the system clock domain
  typedef struct packed {
    logic line_short;
    logic width_bad;
    logic pix_count_bad;
    logic line_count_bad;
    logic frame_slow;
  } pnl_err_s;

endpackage
